// >>> hw/wff_cfg.svh
// offsets, field positions, reset values and counts for the wake frame filter
`ifndef WFF_CFG_SVH
`define WFF_CFG_SVH
`define WFF_NUM_FILT     4
`define WFF_TBL_WORDS    8
`define WFF_ADDR_W       6
`define WFF_WIDX_CTRL    4'h8
`define WFF_MASK_WORD0   0
`define WFF_CMD_WORD     4
`define WFF_OFFS_WORD    5
`define WFF_CRC_WORD0    6
`define WFF_RSV_MASK     32'h7FFF_FFFF
`define WFF_RSV_CMD      32'h0909_0909
`define WFF_RSV_OPEN     32'hFFFF_FFFF
`define WFF_CMD_EN       0
`define WFF_CMD_MCAST    3
`define WFF_CTL_PPEN     1
`define WFF_CTL_WFEN     2
`define WFF_CTL_PPRX     4
`define WFF_CTL_WFRX     5
`define WFF_CTL_IRQEN    8
`define WFF_CTL_PMEEN    9
`define WFF_CTL_RW_MASK  32'h0000_0306
`define WFF_CTL_RESET    32'h0000_0000
`define WFF_SYNC_BYTE    8'hFF
`define WFF_SYNC_LEN     3'h6
`define WFF_ADDR_LAST    3'h5
`define WFF_REPS         5'h10
`define WFF_HDR_LEN      11'h00C
`define WFF_DA_LEN       11'h006
`define WFF_WIN_LEN      11'h01F
`define WFF_IDX_MAX      11'h7FF
`define WFF_CRC_POLY     16'h8005
`define WFF_CRC_INIT     16'hFFFF
`define WFF_RESP_OKAY    2'h0
`define WFF_RESP_SLVERR  2'h2
`endif

// >>> hw/wff_crc_filter.sv
// one wake-up frame filter: masked crc-16 over a 31 byte window
`timescale 1ns/1ps
`include "wff_cfg.svh"
module wff_crc_filter
   import wff_pkg::*;
#(
   parameter logic [15:0] POLY = `WFF_CRC_POLY,
   parameter logic [15:0] INIT = `WFF_CRC_INIT
) (
   input  wire logic  clk,
   input  wire logic  rst_n,
   wff_rx_if.snk      rx,
   input  wire logic [30:0] mask,
   input  wire logic [3:0]  cmd,
   input  wire logic [7:0]  offs,
   input  wire logic [15:0] crc_val,
   output logic              hit
);
   logic [15:0] crc_r;     // running crc
   logic [15:0] crc_cur;   // value before this byte
   logic [15:0] crc_nxt;   // value after this byte
   wff_idx_t    rel;       // position inside window
   logic        in_win;    // byte falls in window
   logic        take;      // byte feeds crc
   logic        type_ok;   // address type matches

   // serial crc, lsb first, one byte
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input wff_byte_t d);
      logic [15:0] v;
      v = c;
      for (int b = 0; b < 8; b++) begin
         v = (v[15] ^ d[b]) ? ((v << 1) ^ POLY) : (v << 1);
      end
      return v;
   endfunction

   // window counted from first destination byte
   assign rel     = rx.idx - {3'h0, offs};
   assign in_win  = (rx.idx >= {3'h0, offs}) && (rel < `WFF_WIN_LEN);
   assign take    = rx.valid && in_win && mask[rel[4:0]];
   assign crc_cur = rx.sof ? INIT : crc_r;
   assign crc_nxt = take ? crc_byte(crc_cur, rx.data) : crc_cur;
   // group filters see only group frames, others only own unicast
   assign type_ok = cmd[`WFF_CMD_MCAST] ? rx.mcast : (!rx.mcast && rx.uc_ok);
   // compare at last byte; broadcast passes as group frame
   assign hit = rx.valid && rx.eof && cmd[`WFF_CMD_EN] && type_ok
                && (crc_nxt == crc_val);

   // crc accumulator
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_r <= `WFF_CRC_INIT;
      end else if (rx.valid) begin
         crc_r <= crc_nxt;
      end
   end
endmodule // wff_crc_filter

// >>> hw/wff_pattern_det.sv
// sync stream and sixteen station address copies search
`timescale 1ns/1ps
`include "wff_cfg.svh"
module wff_pattern_det
   import wff_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   wff_rx_if.snk          rx,
   input  wire wff_mac_t  sta,
   output logic           hit
);
   wff_pd_state_t state_r, state_nxt;    // search state
   logic [2:0]    ff_r, ff_nxt;          // sync bytes seen
   logic [2:0]    pos_r, pos_nxt;        // byte within address copy
   logic [4:0]    rep_r, rep_nxt;        // complete copies seen
   logic          found_r, found_nxt;    // pattern seen this frame
   wff_byte_t     exp_b;                 // expected address byte
   logic          is_ff;                 // byte is sync value

   assign exp_b = sta[{pos_r, 3'h0} +: 8];
   assign is_ff = (rx.data == `WFF_SYNC_BYTE);

   // next search state for each byte
   always_comb begin
      state_nxt = state_r;
      ff_nxt    = ff_r;
      pos_nxt   = pos_r;
      rep_nxt   = rep_r;
      found_nxt = rx.sof ? 1'b0 : found_r;
      if (rx.sof || rx.idx < `WFF_HDR_LEN) begin
         // skip addresses, fresh search per frame
         state_nxt = WFF_HUNT;
         ff_nxt    = 3'h0;
      end else begin
         case (state_r)
            WFF_HUNT: begin
               ff_nxt = is_ff ? ff_r + 3'h1 : 3'h0;
               if (is_ff && ff_r + 3'h1 == `WFF_SYNC_LEN) begin
                  state_nxt = WFF_ADDR;
                  pos_nxt   = 3'h0;
                  rep_nxt   = 5'h0;
               end
            end
            WFF_ADDR: begin
               if (rx.data == exp_b) begin
                  // copies must follow back to back
                  pos_nxt = (pos_r == `WFF_ADDR_LAST) ? 3'h0 : pos_r + 3'h1;
                  if (pos_r == `WFF_ADDR_LAST) begin
                     rep_nxt = rep_r + 5'h1;
                     if (rep_r + 5'h1 == `WFF_REPS) begin
                        found_nxt = 1'b1;
                        state_nxt = WFF_HUNT;
                        ff_nxt    = 3'h0;
                     end
                  end
               end else if (is_ff && pos_r == 3'h0 && rep_r == 5'h0) begin
                  state_nxt = WFF_ADDR;                     // longer sync run
               end else begin
                  // broken copy: restart, an ff may open new sync
                  state_nxt = WFF_HUNT;
                  ff_nxt    = is_ff ? 3'h1 : 3'h0;
               end
            end
            default: begin
               state_nxt = WFF_HUNT;
               ff_nxt    = 3'h0;
            end
         endcase
      end
   end

   // report at frame end only, so a bad tail cannot wake
   assign hit = rx.valid && rx.eof && found_nxt;

   // search registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= WFF_HUNT;
         ff_r    <= 3'h0;
         pos_r   <= 3'h0;
         rep_r   <= 5'h0;
         found_r <= 1'b0;
      end else if (rx.valid) begin
         state_r <= state_nxt;
         ff_r    <= ff_nxt;
         pos_r   <= pos_nxt;
         rep_r   <= rep_nxt;
         found_r <= found_nxt;
      end
   end
endmodule // wff_pattern_det

// >>> hw/wff_pkg.sv
// shared types of the wake frame filter block
package wff_pkg;
   typedef logic [7:0]  wff_byte_t;   // one received byte
   typedef logic [10:0] wff_idx_t;    // byte position in frame
   typedef logic [47:0] wff_mac_t;    // station address
   // sync / repetition search states
   typedef enum logic [1:0] {
      WFF_HUNT = 2'b00,
      WFF_ADDR = 2'b01
   } wff_pd_state_t;
endpackage

// >>> hw/wff_rx_if.sv
// receive byte stream shared by the frame and pattern checkers
`timescale 1ns/1ps
interface wff_rx_if;
   import wff_pkg::*;
   logic      valid;   // byte strobe
   wff_byte_t data;    // byte value
   logic      sof;     // first byte of destination address
   logic      eof;     // last byte of frame
   wff_idx_t  idx;     // position of current byte
   logic      mcast;   // destination is group address
   logic      uc_ok;   // destination equals station address
   modport src (output valid, data, sof, eof, idx, mcast, uc_ok);
   modport snk (input  valid, data, sof, eof, idx, mcast, uc_ok);
endinterface

// >>> hw/wff_top.sv
// wake-up frame filters and pattern packet detector with axi4-lite registers
`timescale 1ns/1ps
`include "wff_cfg.svh"
// Functional notes
// - mask bit j selects byte offset+j
// - command bit 3 picks multicast or unicast
// - command bit 0 enables filter
// - offset counted from first destination byte
// - crc equal to programmed value wakes
// - pattern enable suspends normal reception
// - detection may raise interrupt or power event
// - pattern detection sets pattern received bit
// - clearing enable resumes normal reception
// - examine own unicast or broadcast frames
// - search six ff bytes after addresses
// - sync then sixteen address copies anywhere
// - multicast frames with copies also accepted
// - d1 state enables both detectors automatically
// - frame enable suspends reception, sets received
// - broadcast wake frame ignores broadcast disable
module wff_top
   import wff_pkg::*;
(
   input  wire logic                   CLK_SYS,
   input  wire logic                   RESET_N,
   input  wire logic [`WFF_ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                   S_AXI_AWVALID,
   output logic                        S_AXI_AWREADY,
   input  wire logic [31:0]            S_AXI_WDATA,
   input  wire logic [3:0]             S_AXI_WSTRB,
   input  wire logic                   S_AXI_WVALID,
   output logic                        S_AXI_WREADY,
   output logic [1:0]                  S_AXI_BRESP,
   output logic                        S_AXI_BVALID,
   input  wire logic                   S_AXI_BREADY,
   input  wire logic [`WFF_ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic                   S_AXI_ARVALID,
   output logic                        S_AXI_ARREADY,
   output logic [31:0]                 S_AXI_RDATA,
   output logic [1:0]                  S_AXI_RRESP,
   output logic                        S_AXI_RVALID,
   input  wire logic                   S_AXI_RREADY,
   input  wire logic                   RX_VALID,
   input  wire wff_pkg::wff_byte_t     RX_DATA,
   input  wire logic                   RX_SOF,
   input  wire logic                   RX_EOF,
   input  wire wff_pkg::wff_mac_t      STATION_ADDR,
   input  wire logic                   POWER_D1,
   output logic                        RX_SUSPEND,
   output logic                        HOST_IRQ,
   output logic                        POWER_EVENT_OUTPUT
);
   import wff_pkg::*;

   // write channel holding
   logic        aw_hold_r;        // write address taken
   logic [3:0]  aw_widx_r;        // its word index
   logic        w_hold_r;         // write data taken
   logic [31:0] wdata_r;          // held data
   logic [3:0]  wstrb_r;          // held lanes
   logic        bvalid_r;         // write answer pending
   logic [1:0]  bresp_r;          // write answer code
   logic        do_wr;            // commit this cycle
   logic [31:0] lane_m;           // lanes as bit mask
   // read channel
   logic        rvalid_r;         // read answer pending
   logic [31:0] rdata_r;          // read data
   logic [1:0]  rresp_r;          // read answer code
   logic        rd_take;          // read address taken
   logic [3:0]  ar_widx;          // read word index
   logic [31:0] rd_mux;           // selected word
   logic        rd_map;           // read address mapped
   logic        wr_map;           // write address mapped
   logic        wr_ctrl;          // write hits control word

   // registers
   logic [31:0] tbl_r [`WFF_TBL_WORDS];   // filter table words
   logic [31:0] ctrl_r;                   // wake_control_status
   logic [31:0] ctrl_nxt;
   logic        irq_r;                    // interrupt level
   logic        pme_r;                    // power event level
   logic        susp_r;                   // reception suspended

   // frame tracking
   wff_idx_t    idx_r;            // next byte position
   wff_idx_t    idx_cur;          // position of this byte
   logic        mcast_r;          // group destination
   logic        uc_r;             // destination bytes match so far
   logic        uc_byte;          // this byte matches station byte

   // detection
   logic [`WFF_NUM_FILT-1:0] filt_hit;   // per filter match
   logic        pp_raw;           // pattern found in frame
   logic        pp_act;           // pattern mode active
   logic        wf_act;           // frame mode active
   logic        pp_hit;           // qualified pattern event
   logic        wf_hit;           // qualified frame event
   logic        pp_clr;           // software clears received
   logic        wf_clr;

   wff_rx_if rx_bus ();

   // axi4-lite slave
   assign S_AXI_AWREADY = !aw_hold_r && !bvalid_r;
   assign S_AXI_WREADY  = !w_hold_r && !bvalid_r;
   assign S_AXI_BVALID  = bvalid_r;
   assign S_AXI_BRESP   = bresp_r;
   assign S_AXI_ARREADY = !rvalid_r;
   assign S_AXI_RVALID  = rvalid_r;
   assign S_AXI_RDATA   = rdata_r;
   assign S_AXI_RRESP   = rresp_r;

   // commit once both halves are held, in either order
   assign do_wr   = aw_hold_r && w_hold_r && !bvalid_r;
   assign wr_map  = (aw_widx_r < `WFF_TBL_WORDS) || (aw_widx_r == `WFF_WIDX_CTRL);
   assign wr_ctrl = do_wr && (aw_widx_r == `WFF_WIDX_CTRL);
   assign lane_m  = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   assign rd_take = S_AXI_ARVALID && !rvalid_r;
   assign ar_widx = S_AXI_ARADDR[`WFF_ADDR_W-1:2];
   assign rd_map  = (ar_widx < `WFF_TBL_WORDS) || (ar_widx == `WFF_WIDX_CTRL);
   assign rd_mux  = (ar_widx < `WFF_TBL_WORDS) ? tbl_r[ar_widx[2:0]] :
                    (ar_widx == `WFF_WIDX_CTRL) ? ctrl_r : 32'h0000_0000;

   // write address and data capture
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         aw_hold_r <= 1'b0;
         aw_widx_r <= 4'h0;
         w_hold_r  <= 1'b0;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_r <= 1'b1;
            aw_widx_r <= S_AXI_AWADDR[`WFF_ADDR_W-1:2];
         end else if (do_wr) begin
            aw_hold_r <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_r <= 1'b1;
            wdata_r  <= S_AXI_WDATA;
            wstrb_r  <= S_AXI_WSTRB;
         end else if (do_wr) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   // write answer; unmapped words answer slverr and change nothing
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `WFF_RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_map ? `WFF_RESP_OKAY : `WFF_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= `WFF_RESP_OKAY;
      end else if (rd_take) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_map ? `WFF_RESP_OKAY : `WFF_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   // filter table: eight words, reserved bits kept at zero
   generate
      for (genvar w = 0; w < `WFF_TBL_WORDS; w++) begin : g_tbl
         // mask bit 31 and command bits 2:1 never store
         localparam logic [31:0] KEEP = (w < `WFF_CMD_WORD)  ? `WFF_RSV_MASK :
                                        (w == `WFF_CMD_WORD) ? `WFF_RSV_CMD  :
                                                               `WFF_RSV_OPEN;
         always_ff @(posedge CLK_SYS or negedge RESET_N) begin
            if (!RESET_N) begin
               tbl_r[w] <= 32'h0000_0000;
            end else if (do_wr && aw_widx_r == 4'(w)) begin
               // offset below twelve is software's fault, stored as given
               tbl_r[w] <= ((tbl_r[w] & ~lane_m) | (wdata_r & lane_m)) & KEEP;
            end
         end
      end
   endgenerate

   // frame tracking on the receive byte stream
   assign idx_cur = RX_SOF ? 11'h000 : idx_r;   // byte zero is first da byte
   assign uc_byte = (idx_cur < `WFF_DA_LEN) &&
                    (RX_DATA == STATION_ADDR[{idx_cur[2:0], 3'h0} +: 8]);

   // position counter and destination classification
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         idx_r   <= 11'h000;
         mcast_r <= 1'b0;
         uc_r    <= 1'b0;
      end else if (RX_VALID) begin
         idx_r <= (idx_cur == `WFF_IDX_MAX) ? idx_cur : idx_cur + 11'h001;
         if (RX_SOF) begin
            mcast_r <= RX_DATA[0];
            uc_r    <= uc_byte;
         end else if (idx_cur < `WFF_DA_LEN) begin
            uc_r <= uc_r && uc_byte;
         end
      end
   end

   assign rx_bus.valid = RX_VALID;
   assign rx_bus.data  = RX_DATA;
   assign rx_bus.sof   = RX_SOF;
   assign rx_bus.eof   = RX_EOF;
   assign rx_bus.idx   = idx_cur;
   assign rx_bus.mcast = mcast_r;
   assign rx_bus.uc_ok = uc_r && (idx_r >= `WFF_DA_LEN);

   // four crc filters
   generate
      for (genvar f = 0; f < `WFF_NUM_FILT; f++) begin : g_filt
         wff_crc_filter u_filt (
            .clk     (CLK_SYS),
            .rst_n   (RESET_N),
            .rx      (rx_bus.snk),
            .mask    (tbl_r[`WFF_MASK_WORD0 + f][30:0]),
            .cmd     (tbl_r[`WFF_CMD_WORD][8*f +: 4]),
            .offs    (tbl_r[`WFF_OFFS_WORD][8*f +: 8]),
            .crc_val (tbl_r[`WFF_CRC_WORD0 + f/2][16*(f%2) +: 16]),
            .hit     (filt_hit[f])
         );
      end
   endgenerate

   // pattern packet search
   wff_pattern_det u_pat (
      .clk   (CLK_SYS),
      .rst_n (RESET_N),
      .rx    (rx_bus.snk),
      .sta   (STATION_ADDR),
      .hit   (pp_raw)
   );

   // mode and event qualification
   // d1 forces both detectors on regardless of the enable bits
   assign pp_act = ctrl_r[`WFF_CTL_PPEN] || POWER_D1;
   assign wf_act = ctrl_r[`WFF_CTL_WFEN] || POWER_D1;
   // own unicast, broadcast, or any group address
   assign pp_hit = pp_act && pp_raw && (mcast_r || rx_bus.uc_ok);
   assign wf_hit = wf_act && (|filt_hit);
   assign pp_clr = wr_ctrl && wdata_r[`WFF_CTL_PPRX] && wstrb_r[0];
   assign wf_clr = wr_ctrl && wdata_r[`WFF_CTL_WFRX] && wstrb_r[0];

   // control/status next value: rw bits by lane, received bits sticky
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = (ctrl_r & ~(lane_m & `WFF_CTL_RW_MASK)) |
                    (wdata_r & lane_m & `WFF_CTL_RW_MASK);
      end
      // write-one clears, a new detection in the same cycle wins
      ctrl_nxt[`WFF_CTL_PPRX] = pp_hit || (ctrl_r[`WFF_CTL_PPRX] && !pp_clr);
      ctrl_nxt[`WFF_CTL_WFRX] = wf_hit || (ctrl_r[`WFF_CTL_WFRX] && !wf_clr);
   end

   // status register and notification outputs
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_r <= `WFF_CTL_RESET;
         irq_r  <= 1'b0;
         pme_r  <= 1'b0;
         susp_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         // level outputs follow the sticky bits until software clears
         irq_r  <= ctrl_nxt[`WFF_CTL_IRQEN] &&
                   (ctrl_nxt[`WFF_CTL_PPRX] || ctrl_nxt[`WFF_CTL_WFRX]);
         pme_r  <= ctrl_nxt[`WFF_CTL_PMEEN] &&
                   (ctrl_nxt[`WFF_CTL_PPRX] || ctrl_nxt[`WFF_CTL_WFRX]);
         // normal path stays off while any detector runs
         susp_r <= ctrl_nxt[`WFF_CTL_PPEN] || ctrl_nxt[`WFF_CTL_WFEN] || POWER_D1;
      end
   end

   assign HOST_IRQ           = irq_r;
   assign POWER_EVENT_OUTPUT = pme_r;
   assign RX_SUSPEND         = susp_r;
endmodule // wff_top

// >>> testbench/tb_top.sv
// testbench: registers, pattern packets and crc filters through the ports
`timescale 1ns/1ps
module tb_top;
   import wff_pkg::*;
   logic        CLK_SYS = 1'h0, RESET_N = 1'h0, POWER_D1 = 1'h0;
   logic        S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
   logic        S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
   logic [5:0]  S_AXI_AWADDR = 6'h00, S_AXI_ARADDR = 6'h00;
   logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA;
   logic [3:0]  S_AXI_WSTRB = 4'hF;   // full words only
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic        RX_VALID, RX_SOF, RX_EOF, RX_SUSPEND, HOST_IRQ, POWER_EVENT_OUTPUT;
   wff_byte_t   RX_DATA, f[$];         // f: frame being built
   wff_mac_t    STATION_ADDR = 48'h0000_0000_0000;
   integer      seed = 32'h8a6e, num_errors = 0, n_checks = 0;
   logic [31:0] rq[$];                 // expected read words, oldest first
   logic [30:0] m;
   logic [7:0]  o;
   logic        h;
   wff_top dut_u (.*);
   wff_rx_model rx_u (.*);
   always #5 CLK_SYS = ~CLK_SYS;
   task automatic chk(input string n, logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // write: both channels offered together, each dropped once taken
   task automatic wr(input logic [5:0] a, logic [31:0] d);
      logic pa = 1'h1, pw = 1'h1;
      @(posedge CLK_SYS);
      S_AXI_AWADDR  <= a;
      S_AXI_WDATA   <= d;
      S_AXI_AWVALID <= 1'h1;
      S_AXI_WVALID  <= 1'h1;
      S_AXI_BREADY  <= 1'h1;
      while (pa || pw) begin
         @(posedge CLK_SYS);
         if (S_AXI_AWREADY === 1'h1) pa = 1'h0;
         if (S_AXI_WREADY === 1'h1) pw = 1'h0;
         S_AXI_AWVALID <= pa;
         S_AXI_WVALID  <= pw;
      end
      do @(posedge CLK_SYS); while (S_AXI_BVALID !== 1'h1);
      chk("bresp", 32'(S_AXI_BRESP), a > 6'h23 ? 32'h0000_0002 : 32'h0000_0000);
      S_AXI_BREADY <= 1'h0;
   endtask
   // read: the expectation waits in rq for the monitor
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      rq.push_back(e);
      @(posedge CLK_SYS);
      S_AXI_ARADDR  <= a;
      S_AXI_ARVALID <= 1'h1;
      S_AXI_RREADY  <= 1'h1;
      do @(posedge CLK_SYS); while (S_AXI_ARREADY !== 1'h1);
      S_AXI_ARVALID <= 1'h0;
      do @(posedge CLK_SYS); while (S_AXI_RVALID !== 1'h1);
      S_AXI_RREADY <= 1'h0;
   endtask
   always @(posedge CLK_SYS)
      if (S_AXI_RVALID === 1'h1 && S_AXI_RREADY) chk("rdata", S_AXI_RDATA, rq.pop_front());
   // destination, then a random source address
   task automatic hdr(input wff_mac_t da);
      f.delete();
      for (int i = 0; i < 12; i++) f.push_back(i < 6 ? da[8*i +: 8] : 8'($random(seed)));
   endtask
   // reference crc, lsb first
   function automatic logic [15:0] crc16(input logic [30:0] mk, input logic [7:0] of);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 0; i < 31; i++)
         for (int b = 0; b < 8; b++)
            if (mk[i]) c = (c[15] ^ f[of+i][b]) ? (c << 1) ^ 16'h8005 : c << 1;
      return c;
   endfunction
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      STATION_ADDR <= {16'($random(seed)), 32'($random(seed))} & 48'hFFFF_FFFF_FFFE;
      repeat (12) @(posedge CLK_SYS);
      RESET_N <= 1'h1;
      rd(6'h20, 32'h0000_0000);
      wr(6'h00, 32'hFFFF_FFFF);
      rd(6'h00, 32'h7FFF_FFFF);
      wr(6'h24, 32'hFFFF_FFFF);
      rd(6'h24, 32'h0000_0000);
      wr(6'h10, 32'hFFFF_FFFF);
      rd(6'h10, 32'h0909_0909);
      wr(6'h20, 32'hFFFF_FFFF);
      rd(6'h20, 32'h0000_0306);
      chk("suspend", 32'(RX_SUSPEND), 32'h0000_0001);
      wr(6'h20, 32'h0000_0000);
      repeat (3) @(posedge CLK_SYS);
      chk("suspend", 32'(RX_SUSPEND), 32'h0000_0000);
      POWER_D1 <= 1'h1;
      repeat (3) @(posedge CLK_SYS);
      chk("suspend", 32'(RX_SUSPEND), 32'h0000_0001);
      POWER_D1 <= 1'h0;
      $display("test registers done");
      // own, group, 15 copies, restart, foreign
      wr(6'h20, 32'h0000_0102);
      for (int k = 0; k < 5; k++) begin
         hdr(k == 1 ? 48'h0000_0000_0001 : k == 4 ? STATION_ADDR ^ 48'h0200 : STATION_ADDR);
         if (k == 3) f = {f, 8'hFF, 8'hFF, 8'h00, 8'hFF};
         repeat (6) f.push_back(8'hFF);
         repeat (k == 2 ? 15 : 16)
            for (int i = 0; i < 6; i++) f.push_back(STATION_ADDR[8*i +: 8]);
         f.push_back(8'h00);
         rx_u.send(f);
         repeat (2) @(posedge CLK_SYS);
         h = (k != 2 && k != 4);
         chk("irq", 32'(HOST_IRQ), 32'(h));
         rd(6'h20, h ? 32'h0000_0112 : 32'h0000_0102);
         wr(6'h20, 32'h0000_0112);
      end
      $display("test pattern done");
      // unicast, off, wrong type, broadcast
      wr(6'h20, 32'h0000_0204);
      for (int c = 0; c < 4; c++) begin
         m = 31'($random(seed)) | 31'h0000_0001;
         o = 8'h0C + 8'($random(seed) & 7);
         hdr(c == 3 ? 48'hFFFF_FFFF_FFFF : STATION_ADDR);
         repeat (40) f.push_back(8'($random(seed)));
         for (int w = 0; w < 4; w++) wr(6'(4*w), w == c ? {1'h0, m} : 32'h0000_0000);
         wr(6'h10, 32'(c == 0 ? 4'h7 : c == 1 ? 4'h0 : 4'h9) << 8*c);
         wr(6'h14, 32'(o) << 8*c);
         wr(6'h18, c < 2 ? 32'(crc16(m, o)) << 16*c : 32'h0000_0000);
         wr(6'h1C, c > 1 ? 32'(crc16(m, o)) << 16*(c-2) : 32'h0000_0000);
         rx_u.send(f);
         repeat (2) @(posedge CLK_SYS);
         h = (c == 0 || c == 3);
         chk("pme", 32'(POWER_EVENT_OUTPUT), 32'(h));
         rd(6'h20, h ? 32'h0000_0224 : 32'h0000_0204);
         wr(6'h20, 32'h0000_0224);
      end
      $display("test filters done");
      wrap_up();
   end
   // watchdog, far past test length
   initial begin
      #300_000;
      num_errors++;
      wrap_up();
   end
endmodule // tb_top
bind wff_top wff_top_props chk_u (.*);

// >>> testbench/wff_rx_model.sv
// receive path model: hands whole frames to the block one byte per edge
`timescale 1ns/1ps
module wff_rx_model
   import wff_pkg::*;
(
   input  wire logic CLK_SYS,
   output logic      RX_VALID = 1'h0,
   output wff_byte_t RX_DATA = 8'h00,
   output logic      RX_SOF = 1'h0,
   output logic      RX_EOF = 1'h0
);
   // idle gap every fifth byte; idle data shows the inverse, never a stale byte
   task automatic send(input wff_byte_t fr[$]);
      for (int i = 0; i < fr.size(); i++) begin
         @(posedge CLK_SYS);
         if (i % 5 == 4) begin
            RX_VALID <= 1'h0;
            RX_DATA  <= ~RX_DATA;
            @(posedge CLK_SYS);
         end
         RX_VALID <= 1'h1;
         RX_DATA  <= fr[i];
         RX_SOF   <= (i == 0);   // first destination byte is position zero
         RX_EOF   <= (i == fr.size() - 1);
      end
      @(posedge CLK_SYS);
      RX_VALID <= 1'h0;
      RX_DATA  <= ~RX_DATA;
      RX_EOF   <= 1'h0;
   endtask
endmodule // wff_rx_model

// >>> testbench/wff_top_props.sv
// port checker for register reads, suspend control and wake notifications
`timescale 1ns/1ps
module wff_top_props (
   input wire logic        CLK_SYS,
   input wire logic        RESET_N,
   input wire logic [5:0]  S_AXI_ARADDR,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_WVALID,
   input wire logic        RX_VALID,
   input wire logic        RX_EOF,
   input wire logic        POWER_D1,
   input wire logic        RX_SUSPEND,
   input wire logic        HOST_IRQ,
   input wire logic        POWER_EVENT_OUTPUT
);
   default clocking dc @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   wire rd_go = S_AXI_ARVALID && S_AXI_ARREADY;   // read address taken
   // writes act two edges after data
   a_mask_zero: assert property (rd_go && S_AXI_ARADDR < 6'h10
      |=> !S_AXI_RDATA[31]) else $error("mask top bit reads set");
   a_cmd_rsv: assert property (rd_go && S_AXI_ARADDR[5:2] == 4'h4
      |=> (S_AXI_RDATA & 32'hF6F6_F6F6) == 32'h0000_0000) else $error("command pad bits set");
   a_d1_suspend: assert property (POWER_D1
      |=> RX_SUSPEND) else $error("d1 without suspend");
   a_suspend_rise: assert property ($rose(RX_SUSPEND)
      |-> $past(POWER_D1) || $past(S_AXI_WVALID, 2)) else $error("suspend rose uncaused");
   a_suspend_fall: assert property ($fell(RX_SUSPEND)
      |-> !$past(POWER_D1) && ($past(S_AXI_WVALID, 2) || $past(POWER_D1, 2)))
      else $error("suspend fell uncaused");
   a_irq_cause: assert property ($rose(HOST_IRQ)
      |-> $past(RX_VALID && RX_EOF) || $past(S_AXI_WVALID) || $past(S_AXI_WVALID, 2))
      else $error("interrupt rose uncaused");
   a_irq_hold: assert property (HOST_IRQ && !S_AXI_WVALID && !$past(S_AXI_WVALID)
      |=> HOST_IRQ) else $error("interrupt dropped without write");
   a_pme_hold: assert property (POWER_EVENT_OUTPUT && !S_AXI_WVALID && !$past(S_AXI_WVALID)
      |=> POWER_EVENT_OUTPUT) else $error("power event dropped without write");
endmodule // wff_top_props
